// ### iso_spi_ctrl.sv
// SPI controller for the configuration port, driven from APB registers.
// Assumes an APB master on pclk and the device end on the serial link.
`timescale 1ns/1ps
`default_nettype none
`include "iso_spi_map.svh"

module iso_spi_ctrl
    import iso_spi_pkg::*;
#(
    parameter int SCLK_HALF = 8
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    iso_spi_if.ctrl          spi
);

    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

    host_state_t h_reg;
    host_state_t h_next;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic setup;
        logic wr;
        logic busy;
        logic tick_end;
        h_next = h_reg;
        h_next.miso_s = {h_reg.miso_s[0], spi.miso};
        busy     = (h_reg.phase != H_IDLE);
        setup    = psel & ~penable;
        wr       = psel & penable & pwrite;
        tick_end = (h_reg.tick == HALF_LAST);
        h_next.tick = tick_end ? 8'd0 : h_reg.tick + 8'd1;
        h_next.pready = 1'b1;

        // Read data and error are prepared in the setup cycle
        if (setup) begin
            h_next.pslverr = 1'b0;
            h_next.prdata  = 32'h00000000;
            unique case (paddr)
                `HOST_CTRL: h_next.prdata = {28'h0000000, h_reg.addr, h_reg.dir, 1'b0};
                `HOST_TXD:  h_next.prdata = {8'h00, h_reg.txd};
                `HOST_RXD:  h_next.prdata = {8'h00, h_reg.rx};
                `HOST_STAT: h_next.prdata = {30'h0, h_reg.done, busy};
                default:    h_next.pslverr = 1'b1;
            endcase
        end

        // Writes take effect at the completing edge
        if (wr) begin
            unique case (paddr)
                `HOST_CTRL: begin
                    if (!busy) begin
                        h_next.dir  = pwdata[`CTRL_DIR];
                        h_next.addr = pwdata[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
                        if (pwdata[`CTRL_START]) begin
                            h_next.phase = H_SETUP;
                            h_next.tick  = 8'd0;
                            h_next.cs_n  = 1'b0;
                            h_next.cnt   = 6'd0;
                            // Zero-filled bits sent as zeros
                            h_next.sr = {pwdata[`CTRL_DIR], pwdata[`CTRL_ADDR_HI:`CTRL_ADDR_LO],
                                         5'b00000, h_reg.txd};
                        end
                    end
                end
                `HOST_TXD:  if (!busy) h_next.txd = pwdata[23:0];
                `HOST_STAT: if (pwdata[`STAT_DONE]) h_next.done = 1'b0;
                default: ;
            endcase
        end

        // Serial sequencer
        unique case (h_reg.phase)
            H_IDLE: ;
            H_SETUP: begin
                if (tick_end) begin
                    h_next.phase = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (tick_end) begin
                    if (!h_reg.sclk) begin
                        // Leading edge: present next bit, most significant first
                        h_next.sclk = 1'b1;
                        h_next.mosi = h_reg.sr[`FRAME_BITS-1];
                        h_next.sr   = {h_reg.sr[`FRAME_BITS-2:0], 1'b0};
                    end else begin
                        // Trailing edge: sample answer
                        h_next.sclk = 1'b0;
                        h_next.rx   = {h_reg.rx[22:0], h_reg.miso_s[1]};
                        h_next.cnt  = h_reg.cnt + 6'd1;
                        if (h_reg.cnt == `FRAME_CNT - 6'd1) begin
                            h_next.phase = H_HOLD;
                        end
                    end
                end
            end
            H_HOLD: begin
                if (tick_end) begin
                    h_next.cs_n  = 1'b1;
                    h_next.mosi  = 1'b0;
                    h_next.phase = H_GAP;
                end
            end
            H_GAP: begin
                if (tick_end) begin
                    h_next.phase = H_IDLE;
                    h_next.done  = 1'b1;   // Set wins over a same-cycle clear
                end
            end
            default: h_next.phase = H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_reg       <= '0;
            h_reg.phase <= H_IDLE;
            h_reg.cs_n  <= 1'b1;
        end else begin
            h_reg <= h_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata   = h_reg.prdata;
    assign pready   = h_reg.pready;
    assign pslverr  = h_reg.pslverr;
    assign spi.sclk = h_reg.sclk;
    assign spi.cs_n = h_reg.cs_n;
    assign spi.mosi = h_reg.mosi;

endmodule

`default_nettype wire

// ### iso_spi_dev.sv
// Configuration port of the isolated gate driver: serial slave, three
// 24-bit registers, nonvolatile store model and the keyed isolation link.
// Assumes link pins come from another domain and are resynchronised here.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "iso_spi_map.svh"

module iso_spi_dev
    import iso_spi_pkg::*;
#(
    parameter int CAR_DIV  = 4,
    parameter int CAR_HOLD = 10
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Serial link
    iso_spi_if.drv           spi,
    // Input side
    input  wire logic        pwm_in,
    input  wire logic        input_powered,
    input  wire logic [3:0]  ecc_err_in,
    // Isolated side
    output logic             gate_out,
    output logic [5:0]       remote_sensor_b_offset,
    output logic [5:0]       remote_sensor_b_gain,
    output logic [5:0]       remote_sensor_a_offset,
    output logic [5:0]       remote_sensor_a_gain,
    output logic [23:0]      option_settings,
    output logic             prog_busy,
    output logic             carrier_keying
);

    localparam logic [10:0] PROG_CYC = 11'(`NVM_PROG_US * `CLK_MHZ);
    localparam logic [3:0]  DIV_LAST = 4'(CAR_DIV - 1);
    localparam logic [3:0]  HOLD_CNT = 4'(CAR_HOLD);

    dev_state_t s_reg;
    dev_state_t s_next;

    // Register read mux, unmapped address reads zero
    function automatic logic [23:0] read_reg(input dev_state_t st, input logic [1:0] a);
        logic [23:0] v;
        v = 24'h000000;
        unique case (a)
            `ADDR_TRIM: v = st.trim;
            `ADDR_OPT:  v = st.opt & `OPT_USED_MASK;
            `ADDR_STAT: begin
                v[`STAT_SIM_TRIM]              = st.sim_trim;
                v[`STAT_PROG_BUSY]             = st.busy;
                v[`STAT_ECC_HI:`STAT_ECC_LO]   = st.ecc;
            end
            default:    v = 24'h000000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic        sel;
        logic        rise;
        logic        fall;
        logic [31:0] nsr;
        logic        level;
        sel    = 1'b0;
        rise   = 1'b0;
        fall   = 1'b0;
        nsr    = 32'h00000000;
        level  = 1'b0;
        s_next = s_reg;

        // Two-flop synchronisers on the link, PWM and power pins; ecc_err_in is used unsynchronised
        s_next.cs_s   = {s_reg.cs_s[0], spi.cs_n};
        s_next.sclk_s = {s_reg.sclk_s[0], spi.sclk};
        s_next.mosi_s = {s_reg.mosi_s[0], spi.mosi};
        s_next.pwm_s  = {s_reg.pwm_s[0], pwm_in};
        s_next.pwr_s  = {s_reg.pwr_s[0], input_powered};
        s_next.sclk_d = s_reg.sclk_s[1];

        sel     = ~s_reg.cs_s[1];
        rise    = sel & s_reg.sclk_s[1] & ~s_reg.sclk_d;
        fall    = sel & ~s_reg.sclk_s[1] & s_reg.sclk_d;
        s_next.oe = sel;

        // Frame starts fresh each time select falls
        if (!sel) begin
            s_next.cnt = 6'd0;
        end

        // Leading edge presents the next bit, most significant first
        if (rise) begin
            s_next.miso = s_reg.sr[`FRAME_BITS-1];
        end

        // Trailing edge samples; the register doubles as chain delay line
        if (fall) begin
            nsr = {s_reg.sr[`FRAME_BITS-2:0], s_reg.mosi_s[1]};
            if (s_reg.cnt == `HDR_LAST_CNT && !nsr[`HDR_BITS-1]) begin
                // Header done with read direction: load data for shift out
                nsr = {read_reg(s_reg, nsr[`HDR_BITS-2:`HDR_BITS-3]), nsr[`HDR_BITS-1:0]};
            end
            s_next.sr = nsr;
            if (s_reg.cnt != 6'h3f) begin
                s_next.cnt = s_reg.cnt + 6'd1;
            end
        end

        // Error flags: set wins over a clear in the same cycle
        s_next.ecc = s_reg.ecc;

        // Frame closes on select rising: the last 32 bits are our frame
        // Rise seen on the synced select against last cycle's select
        if (s_reg.cs_s[1] && s_reg.oe && s_reg.cnt >= `FRAME_CNT
            && s_reg.sr[`DIR_POS]) begin
            unique case (s_reg.sr[`ADDR_HI:`ADDR_LO])
                `ADDR_TRIM, `ADDR_OPT: begin
                    if (!s_reg.busy) begin
                        // Schedule a store program cycle
                        s_next.busy      = 1'b1;
                        s_next.prog_cnt  = PROG_CYC;
                        s_next.prog_addr = s_reg.sr[`ADDR_HI:`ADDR_LO];
                        s_next.prog_data = s_reg.sr[`DATA_HI:0];
                    end
                end
                `ADDR_STAT: begin
                    s_next.sim_trim = s_reg.sr[`STAT_SIM_TRIM];
                    s_next.ecc = s_reg.ecc & ~s_reg.sr[`STAT_ECC_HI:`STAT_ECC_LO];
                end
                default: ;
            endcase
        end
        s_next.ecc = s_next.ecc | ecc_err_in;

        // Program cycle completes into the nonvolatile image
        if (s_reg.busy) begin
            if (s_reg.prog_cnt == 11'd0) begin
                s_next.busy = 1'b0;
                if (s_reg.prog_addr == `ADDR_TRIM) begin
                    s_next.trim = s_reg.prog_data;
                end else begin
                    s_next.opt = s_reg.prog_data & `OPT_USED_MASK;
                end
            end else begin
                s_next.prog_cnt = s_reg.prog_cnt - 11'd1;
            end
        end

        // Transmit side: carrier only for high level on a powered input
        level = s_reg.pwm_s[1] & s_reg.cs_s[1] & s_reg.pwr_s[1];
        s_next.car_div = (s_reg.car_div == DIV_LAST) ? 4'd0 : s_reg.car_div + 4'd1;
        if (!level) begin
            s_next.car_tx = 1'b0;
        end else if (s_reg.car_div == DIV_LAST) begin
            s_next.car_tx = ~s_reg.car_tx;
        end

        // Receive side: output high only while carrier edges keep coming
        s_next.car_prev = s_reg.car_tx;
        if (s_reg.car_tx != s_reg.car_prev) begin
            s_next.car_hold = HOLD_CNT;
        end else if (s_reg.car_hold != 4'd0) begin
            s_next.car_hold = s_reg.car_hold - 4'd1;
        end
        s_next.gate = (s_reg.car_hold != 4'd0) & s_reg.cs_s[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg      <= '0;
            s_reg.cs_s <= 2'b11;
            s_reg.sclk_s <= 2'b00;
            s_reg.trim <= `TRIM_RESET;
            s_reg.opt  <= `OPT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state register
    assign spi.miso               = s_reg.miso;
    assign spi.miso_oe            = s_reg.oe;
    assign gate_out               = s_reg.gate;
    assign remote_sensor_b_offset = s_reg.trim[`TRIM_OFS_B_HI:`TRIM_OFS_B_LO];
    assign remote_sensor_b_gain   = s_reg.trim[`TRIM_GAIN_B_HI:`TRIM_GAIN_B_LO];
    assign remote_sensor_a_offset = s_reg.trim[`TRIM_OFS_A_HI:`TRIM_OFS_A_LO];
    assign remote_sensor_a_gain   = s_reg.trim[`TRIM_GAIN_A_HI:`TRIM_GAIN_A_LO];
    assign option_settings        = s_reg.opt;
    assign prog_busy              = s_reg.busy;
    assign carrier_keying         = s_reg.car_tx;

endmodule

`default_nettype wire

// ### iso_spi_if.sv
// Serial link between the SPI controller and the configuration port.
// Assumes the testbench resolves the shared data-out wire from miso_oe.
`timescale 1ns/1ps
`default_nettype none

interface iso_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;

    // Controller end drives clock, select and data out
    modport ctrl (output sclk, output cs_n, output mosi, input miso, input miso_oe);
    // Device end answers on miso
    modport drv (input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface

`default_nettype wire

// ### iso_spi_map.svh
// Offsets, field positions, reset values and timing counts of the isolated
// driver configuration port and of its SPI controller.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef ISO_SPI_MAP_SVH
`define ISO_SPI_MAP_SVH

// Frame layout: direction, two address bits, five zero bits, 24 data bits
`define FRAME_BITS      32
`define HDR_BITS        8
`define DIR_POS         31
`define ADDR_HI         30
`define ADDR_LO         29
`define DATA_HI         23
`define HDR_LAST_CNT    6'd7
`define FRAME_CNT       6'd32

// Register addresses inside the frame
`define ADDR_TRIM       2'b00
`define ADDR_OPT        2'b01
`define ADDR_STAT       2'b10

// Sensor trim fields
`define TRIM_OFS_B_HI   23
`define TRIM_OFS_B_LO   18
`define TRIM_GAIN_B_HI  17
`define TRIM_GAIN_B_LO  12
`define TRIM_OFS_A_HI   11
`define TRIM_OFS_A_LO   6
`define TRIM_GAIN_A_HI  5
`define TRIM_GAIN_A_LO  0

// Reset values and implemented bits
`define TRIM_RESET      24'h000000
`define OPT_RESET       24'h00001c
`define OPT_USED_MASK   24'h01ffff

// Status / control fields
`define STAT_SIM_TRIM   0
`define STAT_PROG_BUSY  1
`define STAT_ECC_LO     2
`define STAT_ECC_HI     5

// Timing
`define CLK_MHZ         125
`define NVM_PROG_US     10

// Controller APB register offsets and fields
`define HOST_CTRL       12'h000
`define HOST_TXD        12'h004
`define HOST_RXD        12'h008
`define HOST_STAT       12'h00c
`define CTRL_START      0
`define CTRL_DIR        1
`define CTRL_ADDR_LO    2
`define CTRL_ADDR_HI    3
`define STAT_BUSY       0
`define STAT_DONE       1

`endif

// ### iso_spi_pkg.sv
// Types shared by the configuration port and its controller.
// Assumes iso_spi_map.svh for the constants behind the field widths.
package iso_spi_pkg;

    // Device state
    typedef struct packed {
        logic [1:0]  cs_s;
        logic [1:0]  sclk_s;
        logic [1:0]  mosi_s;
        logic [1:0]  pwm_s;
        logic [1:0]  pwr_s;
        logic        sclk_d;
        logic [31:0] sr;
        logic [5:0]  cnt;
        logic        miso;
        logic        oe;
        logic [23:0] trim;
        logic [23:0] opt;
        logic        sim_trim;
        logic [3:0]  ecc;
        logic        busy;
        logic [10:0] prog_cnt;
        logic [1:0]  prog_addr;
        logic [23:0] prog_data;
        logic [3:0]  car_div;
        logic        car_tx;
        logic        car_prev;
        logic [3:0]  car_hold;
        logic        gate;
    } dev_state_t;

    // Controller sequencer
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_SETUP = 3'b001,
        H_SHIFT = 3'b010,
        H_HOLD  = 3'b011,
        H_GAP   = 3'b100
    } host_phase_t;

    typedef struct packed {
        host_phase_t phase;
        logic [1:0]  miso_s;
        logic [7:0]  tick;
        logic [5:0]  cnt;
        logic [31:0] sr;
        logic [23:0] rx;
        logic [23:0] txd;
        logic        dir;
        logic [1:0]  addr;
        logic        done;
        logic        sclk;
        logic        cs_n;
        logic        mosi;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } host_state_t;

endpackage

// ### iso_spi_sva.sv
// Checker on the serial link between controller and configuration port.
// Assumes it is placed beside the link and fed from its signals.
`timescale 1ns/1ps
`default_nettype none

module iso_spi_sva (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Serial link
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic       sclk_d;
    logic [6:0] rises;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // Count clock rises within one frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d <= 1'b0;
            rises  <= 7'h00;
        end else begin
            sclk_d <= sclk;
            if (cs_n)
                rises <= 7'h00;
            else if (sclk && !sclk_d)
                rises <= rises + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link timing and framing
    a_sclk_idle_low: assert property (
        cs_n |-> !sclk) else $error("clock high while deselected");
    a_lead_before_clock: assert property (
        $fell(cs_n) |-> !sclk [*7]) else $error("clock rose too soon after select");
    a_mosi_hold_high: assert property (
        sclk && $past(sclk) |-> $stable(mosi)) else $error("data out moved while clock high");
    a_miso_hold_low: assert property (
        !cs_n && $past(!cs_n) && !sclk && $past(!sclk) |-> $stable(miso))
        else $error("data in moved while clock low");
    a_frame_length: assert property (
        $rose(cs_n) |-> rises == 7'd32) else $error("frame not 32 clocks");
    a_gap_after_frame: assert property (
        $rose(cs_n) |=> cs_n [*7]) else $error("select gap too short");
    a_oe_off_deselect: assert property (
        cs_n [*5] |-> !miso_oe) else $error("device drives while deselected");
    a_oe_on_select: assert property (
        !cs_n [*5] |-> miso_oe) else $error("device silent while selected");
endmodule

`default_nettype wire

// ### isolated_driver_spi_config_port_test.sv
// Testbench: controller and port joined by a link, a second port bit-banged.
// Assumes the design files and iso_spi_map.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "iso_spi_map.svh"

module isolated_driver_spi_config_port_test;
    localparam int CAR_DIV  = 4;
    localparam int CAR_HOLD = 10;
    logic        pclk, presetn, psel, penable, pwrite, pwm_in, input_powered;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, gate_out, prog_busy, last_err, car, c0;
    logic [63:0] echo;
    logic [3:0]  ecc_err_in;
    logic [23:0] opt, q;
    wire  [23:0] t1, t2;
    int          checks = 0;
    int          mismatches = 0;

    iso_spi_if spi();
    iso_spi_if spi_b();

    ////////////////////////////////////////////////////////////////////////
    // Controller, port, second port and link checker
    iso_spi_ctrl i_iso_spi_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spi(spi));
    iso_spi_dev #(.CAR_DIV(CAR_DIV), .CAR_HOLD(CAR_HOLD)) i_iso_spi_dev (.pclk(pclk),
        .presetn(presetn), .spi(spi), .pwm_in(pwm_in), .input_powered(input_powered),
        .ecc_err_in(ecc_err_in), .gate_out(gate_out), .remote_sensor_b_offset(t1[23:18]),
        .remote_sensor_b_gain(t1[17:12]), .remote_sensor_a_offset(t1[11:6]),
        .remote_sensor_a_gain(t1[5:0]), .option_settings(opt), .prog_busy(prog_busy),
        .carrier_keying(car));
    iso_spi_dev #(.CAR_DIV(CAR_DIV), .CAR_HOLD(CAR_HOLD)) i_iso_spi_dev_b (.pclk(pclk),
        .presetn(presetn), .spi(spi_b), .pwm_in(pwm_in), .input_powered(input_powered),
        .ecc_err_in(ecc_err_in), .gate_out(), .remote_sensor_b_offset(t2[23:18]),
        .remote_sensor_b_gain(t2[17:12]), .remote_sensor_a_offset(t2[11:6]),
        .remote_sensor_a_gain(t2[5:0]), .option_settings(), .prog_busy(), .carrier_keying());
    iso_spi_sva i_iso_spi_sva (.pclk(pclk), .presetn(presetn), .sclk(spi.sclk), .cs_n(spi.cs_n),
        .mosi(spi.mosi), .miso(spi.miso), .miso_oe(spi.miso_oe));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] o);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        o = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One frame through the controller; gate must be off meanwhile
    task xfer(input logic w, input logic [1:0] a, input logic [23:0] d, output logic [23:0] o);
        apb(1'b1, `HOST_TXD, {8'h00, d}, r);
        apb(1'b1, `HOST_CTRL, {28'h0000000, a, w, 1'b1}, r);
        repeat (40) @(posedge pclk);
        chk(gate_out, 32'h0);
        r = 32'h0;
        for (int i = 0; i < 2000 && r[`STAT_DONE] !== 1'b1; i++)
            apb(1'b0, `HOST_STAT, 32'h0, r);
        chk(r[`STAT_DONE], 32'h1);
        apb(1'b0, `HOST_RXD, 32'h0, r);
        o = r[23:0];
        apb(1'b1, `HOST_STAT, 32'h2, r);
    endtask

    // Bit-banged frame of n bits, most significant first, mode 1
    task bang(input int n, input logic [63:0] f);
        spi_b.cs_n <= 1'b0;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            spi_b.sclk <= 1'b1;
            spi_b.mosi <= f[63 - i];
            repeat (8) @(posedge pclk);
            echo = {echo[62:0], spi_b.miso};
            spi_b.sclk <= 1'b0;
            repeat (8) @(posedge pclk);
        end
        spi_b.cs_n <= 1'b1;
        spi_b.mosi <= ~spi_b.mosi;
        repeat (8) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        chk(t1, `TRIM_RESET);
        chk(opt, `OPT_RESET);
        chk(prog_busy, 32'h0);
        xfer(1'b0, `ADDR_STAT, 24'h0, q);
        chk(q, 32'h0);
        $display("t_reset done");
    endtask

    task t_gate;
        pwm_in <= 1'b1;
        repeat (CAR_DIV + 8) @(posedge pclk);
        chk(gate_out, 32'h1);
        c0 = car;
        repeat (CAR_DIV) @(posedge pclk);
        chk(car, {31'h0, ~c0});
        input_powered <= 1'b0;
        repeat (CAR_HOLD + 6) @(posedge pclk);
        chk(gate_out, 32'h0);
        chk(car, 32'h0);
        input_powered <= 1'b1;
        repeat (CAR_DIV + 8) @(posedge pclk);
        xfer(1'b0, `ADDR_TRIM, 24'h0, q);
        repeat (CAR_DIV + 8) @(posedge pclk);
        chk(gate_out, 32'h1);
        $display("t_gate done");
    endtask

    task t_trim;
        xfer(1'b1, `ADDR_TRIM, 24'h123456, q);
        chk(prog_busy, 32'h1);
        xfer(1'b1, `ADDR_TRIM, 24'habcdef, q);
        repeat (1300) @(posedge pclk);
        chk(t1, 32'h123456);
        xfer(1'b0, `ADDR_TRIM, 24'h0, q);
        chk(q, 32'h123456);
        xfer(1'b1, `ADDR_OPT, 24'hfe5aa5, q);
        repeat (1300) @(posedge pclk);
        chk(opt, 24'hfe5aa5 & `OPT_USED_MASK);
        xfer(1'b0, `ADDR_OPT, 24'h0, q);
        chk(q, 24'hfe5aa5 & `OPT_USED_MASK);
        $display("t_trim done");
    endtask

    task t_status;
        ecc_err_in <= 4'b0101;
        @(posedge pclk);
        ecc_err_in <= 4'b0000;
        xfer(1'b0, `ADDR_STAT, 24'h0, q);
        chk(q, 32'h14);
        xfer(1'b1, `ADDR_STAT, 24'h00003d, q);
        xfer(1'b0, `ADDR_STAT, 24'h0, q);
        chk(q, 32'h1);
        xfer(1'b1, 2'b11, 24'h777777, q);
        xfer(1'b0, 2'b11, 24'h0, q);
        chk(q, 32'h0);
        apb(1'b0, 12'h010, 32'h0, r);
        chk(last_err, 32'h1);
        chk(r, 32'h0);
        $display("t_status done");
    endtask

    task t_chain;
        bang(64, {8'h80, 24'h111111, 8'h80, 24'h0a0a0a});
        repeat (1300) @(posedge pclk);
        chk(t2, 32'h0a0a0a);
        chk(echo[31:0], 32'h80111111);
        chk(echo[63:32], 32'h0);
        bang(31, {8'h80, 24'h555555, 32'h0});
        repeat (1300) @(posedge pclk);
        chk(t2, 32'h0a0a0a);
        $display("t_chain done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        repeat (40000) @(posedge pclk);
        mismatches++;
        close_out;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, pwm_in} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        input_powered = 1'b1;
        ecc_err_in = 4'h0;
        spi_b.sclk = 1'b0;
        spi_b.cs_n = 1'b1;
        spi_b.mosi = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset;
        t_gate;
        t_trim;
        t_status;
        t_chain;
        close_out;
    end
endmodule

`default_nettype wire
